// file: psi_path_status.sv
// module: path status and indicator logic with apb register access
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - patch lamp when any patching or mixing
// - process lamp when active; bypass when neither
// - light every output wordlength range in use
// - shaped lamp any shaped; flat any flat-only
// - no dither when input not longer than output
// - silent after 10000 zeros; nonzero clears
// - auto lamp when all active channels defeated
// - track-mapping lamp, twenty-bit lamp for variant
// - range-extend lamp, twenty-bit lamp for variant
// - destination lamps show every assigned port
// - dual-wire lamp for high-rate two-wire output
// - flash destination lamp when assignment impossible
// - show selected sync source on six lamps
// - word clock rising edge is sample instant
// - three base lamps plus x2/x4 lamps
// - follow-external lamp when rate tracks reference
// - measure reference, classify standard within tolerance
// - missing reference: local steady, requested flashing
module psi_path_status
  import psi_pkg::*;
#(
  parameter int NUM_CH      = 8,
  parameter int GATE_LEN    = GATE_CYCLES,
  parameter int TOLERANCE   = TOL_COUNT
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // audio samples, one channel per strobe
  input  wire logic        sample_valid_in,
  input  wire logic [2:0]  sample_chan_in,
  input  wire logic [31:0] sample_data_in,
  // word clock reference pin
  input  wire logic        word_rate_reference_in,
  // lamps
  output logic             patch_lamp_out,
  output logic             process_lamp_out,
  output logic             bypass_lamp_out,
  output logic [3:0]       wordlength_lamp_out,
  output logic             shaped_dither_lamp_out,
  output logic             flat_lamp_out,
  output logic             auto_lamp_out,
  output logic             track_mapping_code_out,
  output logic             range_extend_code_out,
  output logic             twenty_bit_variant_out,
  output logic [3:0]       dest_lamp_out,
  output logic             dual_wire_high_rate_out,
  output logic [5:0]       sync_lamp_out,
  output logic [2:0]       base_rate_lamp_out,
  output logic [1:0]       multiplier_lamp_out,
  output logic             follow_ext_lamp_out,
  output logic             irq_out
);

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // chan register per channel: [1:0] dither, [3:2] out wl range,
  // [5:4] in wl range, [6] active, [7] range-extend
  logic [31:0] ctrl_q;
  logic [8:0]  dest_q;
  logic [9:0]  sync_q;
  logic [7:0]  chan_cfg_q [NUM_CH];
  logic [2:0]  chan_sel_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;

  wire apb_acc   = psel_in & penable_in;
  wire apb_wr    = apb_acc & pwrite_in;
  wire apb_rd    = apb_acc & ~pwrite_in;
  wire hit_ctrl  = paddr_in == ADDR_CTRL;
  wire hit_chan  = paddr_in == ADDR_CHAN;
  wire hit_dest  = paddr_in == ADDR_DEST;
  wire hit_sync  = paddr_in == ADDR_SYNC;
  wire hit_lamps = paddr_in == ADDR_LAMPS;
  wire hit_stat  = paddr_in == ADDR_IRQ_STAT;
  wire hit_mask  = paddr_in == ADDR_IRQ_MASK;
  wire hit_ref   = paddr_in == ADDR_REF_CNT;
  wire hit_any   = hit_ctrl | hit_chan | hit_dest | hit_sync | hit_lamps |
                   hit_stat | hit_mask | hit_ref;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q     <= 32'h0000_0000;
      dest_q     <= 9'h000;
      sync_q     <= 10'h000;
      chan_sel_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_q <= pwdata_in;
      if (hit_dest) dest_q <= pwdata_in[8:0];
      if (hit_sync) sync_q <= pwdata_in[9:0];
      if (hit_chan) chan_sel_q <= pwdata_in[10:8];
      if (hit_mask) irq_mask_q <= pwdata_in[2:0];
    end
  end

  // ---------------------------------------------------------------------------
  // per-channel state: config, silence detection, defeat
  // ---------------------------------------------------------------------------
  logic [NUM_CH-1:0] silent;
  logic [NUM_CH-1:0] defeat;
  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0] shaped;
  logic [NUM_CH-1:0] flat;
  logic [NUM_CH-1:0] rext;
  logic [NUM_WL-1:0] wl_use [NUM_CH];
  wire  auto_en = ctrl_q[CTRL_D2D] & ctrl_q[CTRL_AUTO];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [SILENCE_W-1:0] zero_cnt_q;
      logic                 silent_q;
      wire mine  = sample_valid_in && (sample_chan_in == 3'(g));
      wire zero  = sample_data_in == 32'h0000_0000;
      wire cfg_w = apb_wr && hit_chan && (pwdata_in[10:8] == 3'(g));

      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          chan_cfg_q[g] <= 8'h00;
        end else if (cfg_w) begin
          chan_cfg_q[g] <= pwdata_in[7:0];
        end
      end

      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          zero_cnt_q <= '0;
          silent_q   <= 1'b0;
        end else if (mine && !zero) begin
          zero_cnt_q <= '0;
          silent_q   <= 1'b0;
        end else if (mine && !silent_q) begin
          zero_cnt_q <= zero_cnt_q + 1'b1;
          if (zero_cnt_q == SILENCE_W'(SILENCE_COUNT - 1)) begin
            silent_q <= 1'b1;
          end
        end
      end

      assign silent[g] = silent_q;
      assign active[g] = chan_cfg_q[g][6];
      // shorter or equal input needs no dither
      assign defeat[g] = auto_en &&
        ((chan_cfg_q[g][5:4] <= chan_cfg_q[g][3:2]) || silent_q);
      assign shaped[g] = active[g] && !defeat[g] &&
                         chan_cfg_q[g][1:0] == DITH_SHAPED;
      assign flat[g]   = active[g] && !defeat[g] &&
                         chan_cfg_q[g][1:0] == DITH_FLAT;
      assign rext[g]   = active[g] && chan_cfg_q[g][7];
      assign wl_use[g] = active[g] ? (NUM_WL'(1) << chan_cfg_q[g][3:2])
                                   : '0;
    end
  endgenerate

  logic [NUM_WL-1:0] wl_any;
  always_comb begin
    wl_any = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      wl_any = wl_any | wl_use[i];
    end
  end

  wire any_active = |active;
  wire auto_all   = any_active && ((defeat | ~active) == '1);

  // ---------------------------------------------------------------------------
  // flash divider and reference measurement
  // ---------------------------------------------------------------------------
  logic [FLASH_DIV-1:0] flash_cnt_q;
  logic [1:0]           wck_sync_q;
  logic                 wck_prev_q;
  logic [31:0]          gate_cnt_q;
  logic [15:0]          edge_cnt_q;
  logic [15:0]          ref_cnt_q;
  logic                 ref_ok_q;

  wire flash    = flash_cnt_q[FLASH_DIV-1];
  wire wck_rise = wck_sync_q[1] & ~wck_prev_q;
  wire gate_end = gate_cnt_q == 32'(GATE_LEN - 1);

  // edges per 10 ms window for 32k, 44.1k, 48k and multiples
  function automatic logic is_standard(input logic [15:0] n);
    logic hit;
    int   std [9];
    hit = 1'b0;
    std = '{320, 441, 480, 640, 882, 960, 1280, 1764, 1920};
    for (int i = 0; i < 9; i++) begin
      if ((int'(n) + TOLERANCE >= std[i]) &&
          (int'(n) <= std[i] + TOLERANCE)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_standard

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_cnt_q <= '0;
      wck_sync_q  <= 2'h0;
      wck_prev_q  <= 1'b0;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
      wck_sync_q  <= {wck_sync_q[0], word_rate_reference_in};
      wck_prev_q  <= wck_sync_q[1];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_cnt_q <= 32'h0000_0000;
      edge_cnt_q <= 16'h0000;
      ref_cnt_q  <= 16'h0000;
      ref_ok_q   <= 1'b0;
    end else if (gate_end) begin
      gate_cnt_q <= 32'h0000_0000;
      edge_cnt_q <= 16'h0000;
      ref_cnt_q  <= edge_cnt_q;
      ref_ok_q   <= is_standard(edge_cnt_q);
    end else begin
      gate_cnt_q <= gate_cnt_q + 1'b1;
      if (wck_rise) edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // sync source selection with fallback
  // ---------------------------------------------------------------------------
  wire [2:0] src_sel   = sync_q[SYNC_SEL_LO +: 3];
  wire [5:0] src_det   = {sync_q[SYNC_DET_LO+5 -: 4], ref_ok_q, 1'b1};
  wire       src_valid = src_sel < 3'(NUM_SRC);
  wire       src_lost  = src_valid && src_sel != SRC_LOCAL &&
                         !src_det[src_sel];
  logic [5:0] sync_lamp_d;
  always_comb begin
    sync_lamp_d = 6'h00;
    if (src_lost) begin
      sync_lamp_d[SRC_LOCAL] = 1'b1;
      sync_lamp_d[src_sel]   = flash;
    end else if (src_valid) begin
      sync_lamp_d[src_sel]   = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // rate display and interrupts
  // ---------------------------------------------------------------------------
  wire [1:0] base_sel = ctrl_q[CTRL_RATE_LO +: 2];
  wire [1:0] mul_sel  = ctrl_q[CTRL_MUL_LO +: 2];
  wire [2:0] base_d   = (base_sel < 2'h3) ? (3'h1 << base_sel) : 3'h0;
  wire [1:0] mul_d    = (mul_sel == 2'h1) ? 2'h1 :
                        (mul_sel == 2'h2) ? 2'h2 : 2'h0;

  // events: silence entered, reference lost, reference regained
  logic ref_ok_prev_q;
  logic [NUM_CH-1:0] silent_prev_q;
  wire [2:0] irq_ev = {ref_ok_q & ~ref_ok_prev_q,
                       ~ref_ok_q & ref_ok_prev_q,
                       |(silent & ~silent_prev_q)};
  // only the bits handed out at the setup edge may be cleared
  wire [2:0] stat_clr = {3{apb_rd & hit_stat}} & prdata_out[2:0];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_ok_prev_q <= 1'b0;
      silent_prev_q <= '0;
      irq_stat_q    <= 3'h0;
    end else begin
      ref_ok_prev_q <= ref_ok_q;
      silent_prev_q <= silent;
      irq_stat_q    <= (irq_stat_q & ~stat_clr) | irq_ev;
    end
  end

  // ---------------------------------------------------------------------------
  // apb read mux and lamp outputs
  // ---------------------------------------------------------------------------
  wire [31:0] lamp_word = {5'h00, base_rate_lamp_out, multiplier_lamp_out,
                           sync_lamp_out, dest_lamp_out,
                           wordlength_lamp_out, patch_lamp_out,
                           process_lamp_out, bypass_lamp_out,
                           shaped_dither_lamp_out, flat_lamp_out,
                           auto_lamp_out, track_mapping_code_out,
                           range_extend_code_out};
  wire [31:0] rd_d =
    hit_ctrl  ? ctrl_q :
    hit_chan  ? {21'h0, chan_sel_q, chan_cfg_q[chan_sel_q]} :
    hit_dest  ? {23'h0, dest_q} :
    hit_sync  ? {22'h0, sync_q} :
    hit_lamps ? lamp_word :
    hit_stat  ? {29'h0, irq_stat_q} :
    hit_mask  ? {29'h0, irq_mask_q} :
    hit_ref   ? {16'h0, ref_cnt_q} : 32'h0000_0000;

  wire [3:0] dest_d = (dest_q[DEST_PORT_LO +: 4] & ~dest_q[DEST_BAD_LO +: 4]) |
                      (dest_q[DEST_BAD_LO +: 4] & {4{flash}});
  wire trk = ctrl_q[CTRL_TRACK];
  wire rxt = |rext;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit_any;
      if (psel_in & ~penable_in) prdata_out <= rd_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      patch_lamp_out          <= 1'b0;
      process_lamp_out        <= 1'b0;
      bypass_lamp_out         <= 1'b0;
      wordlength_lamp_out     <= 4'h0;
      shaped_dither_lamp_out  <= 1'b0;
      flat_lamp_out           <= 1'b0;
      auto_lamp_out           <= 1'b0;
      track_mapping_code_out  <= 1'b0;
      range_extend_code_out   <= 1'b0;
      twenty_bit_variant_out  <= 1'b0;
      dest_lamp_out           <= 4'h0;
      dual_wire_high_rate_out <= 1'b0;
      sync_lamp_out           <= 6'h00;
      base_rate_lamp_out      <= 3'h0;
      multiplier_lamp_out     <= 2'h0;
      follow_ext_lamp_out     <= 1'b0;
      irq_out                 <= 1'b0;
    end else begin
      patch_lamp_out          <= ctrl_q[CTRL_PATCH];
      process_lamp_out        <= ctrl_q[CTRL_PROC];
      bypass_lamp_out         <= ~ctrl_q[CTRL_PATCH] & ~ctrl_q[CTRL_PROC];
      wordlength_lamp_out     <= wl_any;
      shaped_dither_lamp_out  <= |shaped;
      flat_lamp_out           <= |flat;
      auto_lamp_out           <= auto_en & auto_all;
      track_mapping_code_out  <= trk;
      range_extend_code_out   <= rxt;
      twenty_bit_variant_out  <= (trk & ctrl_q[CTRL_TRK20]) |
                                 (rxt & ctrl_q[CTRL_RANGE20]);
      dest_lamp_out           <= dest_d;
      dual_wire_high_rate_out <= dest_q[DEST_DUAL];
      sync_lamp_out           <= sync_lamp_d;
      base_rate_lamp_out      <= base_d;
      multiplier_lamp_out     <= mul_d;
      follow_ext_lamp_out     <= ctrl_q[CTRL_FOLLOW];
      irq_out                 <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : psi_path_status
`default_nettype wire

// file: psi_path_status_checker.sv
// checker: concurrent properties on the path status block ports
`timescale 1ns/10ps
`default_nettype none
module psi_path_status_checker
  import psi_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        patch_lamp_out,
  input wire logic        process_lamp_out,
  input wire logic        bypass_lamp_out,
  input wire logic        shaped_dither_lamp_out,
  input wire logic        flat_lamp_out,
  input wire logic        auto_lamp_out,
  input wire logic        track_mapping_code_out,
  input wire logic        range_extend_code_out,
  input wire logic        twenty_bit_variant_out,
  input wire logic [3:0]  dest_lamp_out,
  input wire logic        dual_wire_high_rate_out,
  input wire logic [5:0]  sync_lamp_out,
  input wire logic [2:0]  base_rate_lamp_out,
  input wire logic [1:0]  multiplier_lamp_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic wr_acc = psel_in && penable_in && pwrite_in;
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  bypass_when_idle_a: assert property (reset_n_in && $past(reset_n_in) |->
    bypass_lamp_out == !(patch_lamp_out || process_lamp_out))
    else $error("bypass lamp disagrees with patch and process lamps");
  ctrl_lamps_follow_a: assert property (wr_acc && paddr_in == ADDR_CTRL
    |-> ##2 patch_lamp_out == $past(pwdata_in[CTRL_PATCH], 2)
    && process_lamp_out == $past(pwdata_in[CTRL_PROC], 2))
    else $error("patch or process lamp not following control write");
  dest_lamps_follow_a: assert property (wr_acc && paddr_in == ADDR_DEST
    |-> ##2 (dest_lamp_out & ~$past(pwdata_in[7:4], 2))
    == $past(pwdata_in[3:0] & ~pwdata_in[7:4], 2)
    && dual_wire_high_rate_out == $past(pwdata_in[DEST_DUAL], 2))
    else $error("steady destination or dual wire lamp wrong");
  twenty_needs_code_a: assert property (twenty_bit_variant_out |->
    track_mapping_code_out || range_extend_code_out)
    else $error("twenty bit lamp lit without an encoding lamp");
  auto_excludes_dith_a: assert property (auto_lamp_out |->
    !shaped_dither_lamp_out && !flat_lamp_out)
    else $error("dither lamp lit while every channel defeated");
  rate_lamps_legal_a: assert property ($onehot0(base_rate_lamp_out)
    && !(&multiplier_lamp_out))
    else $error("illegal sample rate lamp combination");
  sync_lamps_legal_a: assert property ($countones(sync_lamp_out) <= 2
    && ($countones(sync_lamp_out) != 2 || sync_lamp_out[0]))
    else $error("sync lamps show more than one source");
  apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  unmapped_refused_a: assert property (psel_in && penable_in
    && paddr_in == ADDR_SAMPLE |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  cover property (wr_acc && paddr_in == ADDR_DEST && pwdata_in[7:4] != 4'h0);
  cover property ($rose(auto_lamp_out));
  cover property ($countones(sync_lamp_out) == 2);
endmodule : psi_path_status_checker

bind psi_path_status psi_path_status_checker u_chk (
  .ref_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .patch_lamp_out,
  .process_lamp_out, .bypass_lamp_out, .shaped_dither_lamp_out,
  .flat_lamp_out, .auto_lamp_out, .track_mapping_code_out,
  .range_extend_code_out, .twenty_bit_variant_out, .dest_lamp_out,
  .dual_wire_high_rate_out, .sync_lamp_out, .base_rate_lamp_out,
  .multiplier_lamp_out);
`default_nettype wire

// file: psi_pkg.sv
// package: constants for the path status indicator logic
package psi_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CHAN     = 8'h04;
  localparam logic [7:0] ADDR_DEST     = 8'h08;
  localparam logic [7:0] ADDR_SYNC     = 8'h0c;
  localparam logic [7:0] ADDR_LAMPS    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_REF_CNT  = 8'h1c;
  localparam logic [7:0] ADDR_SAMPLE   = 8'h20;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  // ctrl
  localparam int CTRL_PATCH   = 0;
  localparam int CTRL_PROC    = 1;
  localparam int CTRL_D2D     = 2;
  localparam int CTRL_AUTO    = 3;
  localparam int CTRL_TRACK   = 4;
  localparam int CTRL_TRK20   = 5;
  localparam int CTRL_RANGE20 = 6;
  localparam int CTRL_FOLLOW  = 7;
  localparam int CTRL_RATE_LO = 8;  // 2 bits base, 2 bits multiplier
  localparam int CTRL_MUL_LO  = 10;
  // sync
  localparam int SYNC_SEL_LO  = 0;  // 3 bits
  localparam int SYNC_DET_LO  = 4;  // 6 bits, per-source detect; bits for sources 0 and 1 unused
  // dest
  localparam int DEST_PORT_LO = 0;  // 4 bits assigned
  localparam int DEST_BAD_LO  = 4;  // 4 bits unachievable
  localparam int DEST_DUAL    = 8;

  // ---------------------------------------------------------------------------
  // encodings and counts
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SRC_LOCAL = 3'h0;
  localparam int NUM_SRC       = 6;
  localparam int NUM_WL        = 4;  // 16, 20, 24, 32-bit ranges
  localparam int SILENCE_COUNT = 10000;
  localparam int SILENCE_W     = 14;
  localparam int FLASH_DIV     = 24;  // flash toggles every 2^(FLASH_DIV-1) cycles
  localparam int CLK_HZ        = 200000000;
  localparam int GATE_CYCLES   = 2000000; // 10 ms measuring window
  localparam int TOL_COUNT     = 4;       // tolerance in edges per window

  // dither mode per channel: 0 none, 1 flat, 2 shaped
  localparam logic [1:0] DITH_NONE   = 2'h0;
  localparam logic [1:0] DITH_FLAT   = 2'h1;
  localparam logic [1:0] DITH_SHAPED = 2'h2;

endpackage : psi_pkg

// file: psi_ref_source_model.sv
// model: external word clock reference feeding the sync input pin
`timescale 1ns/10ps
`default_nettype none
module psi_ref_source_model (
  // clock
  input  wire logic       ref_clk_in,
  // bench control
  input  wire logic       run_in,
  input  wire logic [7:0] half_in,
  // reference pin
  output logic            word_rate_reference_out
);
  logic [7:0] cnt_q;
  // an unplugged reference rests low, so no stray edge is ever seen
  always_ff @(posedge ref_clk_in) begin
    if (!run_in) begin
      cnt_q                   <= 8'h00;
      word_rate_reference_out <= 1'b0;
    end else if (cnt_q >= half_in - 8'h01) begin
      cnt_q                   <= 8'h00;
      word_rate_reference_out <= !word_rate_reference_out;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : psi_ref_source_model
`default_nettype wire

// file: testbench.sv
// testbench: self-checking bench for the path status block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import psi_pkg::*;
  logic        ref_clk_in, reset_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, sample_data_in, rd, w;
  logic        pready_out, pslverr_out, sample_valid_in, er, ok, ref_run;
  logic [2:0]  sample_chan_in, base_rate_lamp_out;
  logic        word_rate_reference_in, irq_out, follow_ext_lamp_out;
  logic        patch_lamp_out, process_lamp_out, bypass_lamp_out;
  logic [3:0]  wordlength_lamp_out, dest_lamp_out;
  logic        shaped_dither_lamp_out, flat_lamp_out, auto_lamp_out;
  logic        track_mapping_code_out, range_extend_code_out;
  logic        twenty_bit_variant_out, dual_wire_high_rate_out;
  logic [5:0]  sync_lamp_out;
  logic [1:0]  multiplier_lamp_out;
  logic [6:0]  e;
  int          n_errors = 0;
  int          checks = 0;
  // short window keeps the run brief: a 10-cycle period gives 320 edges
  localparam int GATE = 3200;

  psi_path_status #(.GATE_LEN(GATE)) u_dut (.ref_clk_in, .reset_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .sample_valid_in, .sample_chan_in,
    .sample_data_in, .word_rate_reference_in, .patch_lamp_out,
    .process_lamp_out, .bypass_lamp_out, .wordlength_lamp_out,
    .shaped_dither_lamp_out, .flat_lamp_out, .auto_lamp_out,
    .track_mapping_code_out, .range_extend_code_out,
    .twenty_bit_variant_out, .dest_lamp_out, .dual_wire_high_rate_out,
    .sync_lamp_out, .base_rate_lamp_out, .multiplier_lamp_out,
    .follow_ext_lamp_out, .irq_out);
  psi_ref_source_model u_ref (.ref_clk_in, .run_in(ref_run),
    .half_in(8'h05), .word_rate_reference_out(word_rate_reference_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = !ref_clk_in;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task settle;
    repeat (3) @(posedge ref_clk_in);
  endtask : settle
  task send(input int n, input logic [31:0] d);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk_in);
      sample_valid_in <= 1'b1;
      sample_data_in  <= d;
    end
    @(posedge ref_clk_in);
    sample_valid_in <= 1'b0;
  endtask : send
  task conclude;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  function automatic logic [31:0] ctrl_lamps(input logic [31:0] c);
    logic [2:0] b;
    b = (c[9:8] == 2'h3) ? 3'h0 : 3'h1 << c[9:8];
    return {c[CTRL_PATCH], c[CTRL_PROC], !(c[CTRL_PATCH] || c[CTRL_PROC]),
            c[CTRL_TRACK], c[CTRL_TRACK] && c[CTRL_TRK20], b, c[11:10]};
  endfunction : ctrl_lamps

  initial begin
    repeat (60000) @(posedge ref_clk_in);
    n_errors++;
    conclude;
  end
  initial begin
    {reset_n_in, psel_in, penable_in, pwrite_in, sample_valid_in} = 5'h0;
    {paddr_in, pwdata_in, sample_data_in} = '0;
    sample_chan_in = 3'h0;
    ref_run = 1'b0;
    void'($urandom(65054));
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    settle;
    chk({patch_lamp_out, bypass_lamp_out, auto_lamp_out, irq_out}, 4'h4, "reset");
    for (int i = 0; i < 16; i++) begin
      w = (i == 0) ? 32'h0 : $urandom & 32'h0000_0f7f;
      if (w[11:10] == 2'h3) w[11:10] = 2'h2;
      apb(1'b1, ADDR_CTRL, w);
      settle;
      chk({patch_lamp_out, process_lamp_out, bypass_lamp_out,
           track_mapping_code_out, twenty_bit_variant_out,
           base_rate_lamp_out, multiplier_lamp_out}, ctrl_lamps(w), "ctrl");
    end
    apb(1'b1, ADDR_CTRL, 32'h80);
    settle;
    chk(follow_ext_lamp_out, 1'b1, "follow");
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'h0f : $urandom & 32'h1ff;
      apb(1'b1, ADDR_DEST, w);
      settle;
      chk({dual_wire_high_rate_out, dest_lamp_out},
          {w[DEST_DUAL], w[3:0] & ~w[7:4]}, "dest");
    end
    apb(1'b1, ADDR_CTRL, 32'h40);
    for (int r = 0; r < 4; r++) begin
      e = 7'h0;
      for (int ch = 0; ch < 8; ch++) begin
        w = ($urandom & 32'hbf) | 32'h40;
        if (w[1:0] == 2'h3) w[1:0] = 2'h2;
        e |= {w[7], w[1:0] == 2'h2, w[1:0] == 2'h1, 4'h1 << w[3:2]};
        apb(1'b1, ADDR_CHAN, {21'h0, 3'(ch), w[7:0]});
      end
      settle;
      chk({range_extend_code_out, twenty_bit_variant_out, shaped_dither_lamp_out,
           flat_lamp_out, wordlength_lamp_out}, {e[6], e}, "chan");
    end
    for (int ch = 1; ch < 8; ch++) apb(1'b1, ADDR_CHAN, {21'h0, 3'(ch), 8'h00});
    apb(1'b1, ADDR_CTRL, 32'h0c);
    apb(1'b1, ADDR_CHAN, 32'h4e);
    settle;
    chk({auto_lamp_out, shaped_dither_lamp_out}, 2'h2, "short input");
    apb(1'b1, ADDR_CHAN, 32'h72);
    send(9999, 32'h0);
    settle;
    chk({auto_lamp_out, shaped_dither_lamp_out}, 2'h1, "9999 zeros");
    send(1, 32'h0);
    settle;
    chk({auto_lamp_out, shaped_dither_lamp_out, irq_out}, 3'h4, "silent");
    apb(1'b1, ADDR_CHAN, 32'h172);
    settle;
    chk(auto_lamp_out, 1'b0, "other active");
    apb(1'b1, ADDR_CHAN, 32'h100);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    settle;
    chk(irq_out, 1'b1, "irq raised");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1, "irq status");
    settle;
    chk({auto_lamp_out, irq_out}, 2'h2, "irq cleared");
    send(1, 32'h100);
    settle;
    chk({auto_lamp_out, shaped_dither_lamp_out}, 2'h1, "nonzero");
    for (int s = 0; s < NUM_SRC; s++) begin
      w = 32'h280 | s;
      ok = (s == 0) || (s > 1 && w[s + SYNC_DET_LO]);
      apb(1'b1, ADDR_SYNC, w);
      settle;
      chk(sync_lamp_out, ok ? 6'h01 << s : 6'h01, "sync");
    end
    ref_run <= 1'b1;
    repeat (2 * GATE + 10) @(posedge ref_clk_in);
    apb(1'b0, ADDR_REF_CNT, 32'h0);
    chk(32'(rd >= 319 && rd <= 321), 32'h1, "edge count");
    apb(1'b1, ADDR_SYNC, 32'h1);
    settle;
    chk(sync_lamp_out, 6'h02, "word clock");
    ref_run <= 1'b0;
    repeat (2 * GATE + 10) @(posedge ref_clk_in);
    apb(1'b0, ADDR_REF_CNT, 32'h0);
    chk(rd, 32'h0, "no reference");
    chk(sync_lamp_out, 6'h01, "fallback");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h6, "ref events");
    apb(1'b0, ADDR_SAMPLE, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    conclude;
  end
endmodule : testbench
`default_nettype wire
